// *** rtl/spp_pkg.sv ***
/*
  Shared constants, types and decode for the serial program port.
  Assumes a single 100 MHz system clock; the serial clock is sampled as data.
*/
package spp_pkg;

  // ----------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------
  localparam int CODE_W = 4;
  localparam int INSTR_W = 24;
  localparam int VIS_W = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FORCED_LAST = 5'h08;
  localparam logic [CNT_W-1:0] CODE_LAST = 5'h03;
  localparam logic [CNT_W-1:0] INSTR_LAST = 5'h17;
  localparam logic [CNT_W-1:0] RO_PROC_LAST = 5'h07;
  localparam logic [CNT_W-1:0] RO_OUT_LAST = 5'h0F;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CODE_W-1:0] CODE_EXEC = 4'h0;
  localparam logic [CODE_W-1:0] CODE_READOUT = 4'h1;
  localparam logic [INSTR_W-1:0] NOP_INSTR = 24'h000000;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] REG_NVM_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_NVM_KEY = 4'h1;
  localparam logic [ADDR_W-1:0] REG_VIS = 4'h2;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h3;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam int NVM_START_BIT = 15;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // ----------------------------------------------------------------
  // Memory operation codes
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] OP_ERASE_ALL = 16'h407F;
  localparam logic [DATA_W-1:0] OP_ERASE_DROW = 16'h4075;
  localparam logic [DATA_W-1:0] OP_ERASE_DWORD = 16'h4074;
  localparam logic [DATA_W-1:0] OP_ERASE_EXEC = 16'h4072;
  localparam logic [DATA_W-1:0] OP_ERASE_CROW = 16'h4071;
  localparam logic [DATA_W-1:0] OP_ERASE_BSG = 16'h406E;
  localparam logic [DATA_W-1:0] OP_ERASE_SG = 16'h405E;
  localparam logic [DATA_W-1:0] OP_ERASE_G = 16'h404E;
  localparam logic [DATA_W-1:0] OP_ERASE_BDATA = 16'h4066;
  localparam logic [DATA_W-1:0] OP_ERASE_SDATA = 16'h4056;
  localparam logic [DATA_W-1:0] OP_ERASE_GDATA = 16'h4046;
  localparam logic [DATA_W-1:0] OP_WRITE_CFG = 16'h4008;
  localparam logic [DATA_W-1:0] OP_WRITE_DROW = 16'h4005;
  localparam logic [DATA_W-1:0] OP_WRITE_DWORD = 16'h4004;
  localparam logic [DATA_W-1:0] OP_WRITE_CROW = 16'h4001;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_FORCED = 3'b001,
    ST_INSTR = 3'b010,
    ST_CODE = 3'b011,
    ST_RO_PROC = 3'b100,
    ST_RO_OUT = 3'b101
  } port_state_t;

  typedef enum logic [1:0] {
    NVM_NONE = 2'b00,
    NVM_ERASE = 2'b01,
    NVM_WRITE = 2'b10
  } nvm_kind_t;

  typedef struct packed {
    logic exec;
    logic [INSTR_W-1:0] word;
  } cpu_instr_t;

  typedef struct packed {
    logic active;
    nvm_kind_t kind;
    logic [DATA_W-2:0] op;
  } nvm_cmd_t;

  // Operation decode; bit 15 ignored so it works on the live register
  function automatic nvm_kind_t op_kind(input logic [DATA_W-1:0] v);
    logic [DATA_W-1:0] op;
    op = {1'b0, v[DATA_W-2:0]};
    case (op)
      OP_ERASE_ALL, OP_ERASE_DROW, OP_ERASE_DWORD, OP_ERASE_EXEC, OP_ERASE_CROW,
      OP_ERASE_BSG, OP_ERASE_SG, OP_ERASE_G,
      OP_ERASE_BDATA, OP_ERASE_SDATA, OP_ERASE_GDATA: op_kind = NVM_ERASE;
      OP_WRITE_CFG, OP_WRITE_DROW, OP_WRITE_DWORD, OP_WRITE_CROW: op_kind = NVM_WRITE;
      default: op_kind = NVM_NONE;
    endcase
    if (v[DATA_W-2] == 1'b0) begin
      op_kind = NVM_NONE;
    end
  endfunction

endpackage

// *** rtl/pin_sync.sv ***
/*
  Two-flop synchroniser for asynchronous pin levels.
  Assumes inputs change slowly against i_clk; only the second stage is used.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = i_async;
    sync_next = meta_reg;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg;

endmodule

// *** rtl/nvm_control.sv ***
/*
  Memory control register with unlock key and start/stop of a cycle.
  Assumes one-cycle write strobes from the register port on i_clk.
*/
`timescale 1ns/10ps
module nvm_control (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ctrl_wr,
  input wire logic i_key_wr,
  input wire logic [spp_pkg::DATA_W-1:0] i_wdata,
  output logic [spp_pkg::DATA_W-1:0] o_ctrl,
  output logic o_unlocked,
  output logic o_start,
  output logic o_stop,
  output spp_pkg::nvm_cmd_t o_cmd
);

  // ----------------------------------------------------------------
  // Key and control state
  // ----------------------------------------------------------------
  logic [spp_pkg::DATA_W-1:0] ctrl_reg;
  logic [spp_pkg::DATA_W-1:0] ctrl_next;
  logic key1_reg;
  logic key1_next;
  logic unlock_reg;
  logic unlock_next;
  logic start_reg;
  logic start_next;
  logic stop_reg;
  logic stop_next;
  logic want_set;

  always_comb begin
    ctrl_next = ctrl_reg;
    key1_next = key1_reg;
    unlock_next = unlock_reg;
    start_next = 1'b0;
    stop_next = 1'b0;
    want_set = i_wdata[spp_pkg::NVM_START_BIT] & ~ctrl_reg[spp_pkg::NVM_START_BIT];
    if (i_key_wr) begin
      // Only 0x55 then 0xAA back to back arms the start bit
      key1_next = (i_wdata[7:0] == spp_pkg::KEY_FIRST);
      unlock_next = key1_reg & (i_wdata[7:0] == spp_pkg::KEY_SECOND);
    end else if (i_ctrl_wr) begin
      key1_next = 1'b0;
      unlock_next = 1'b0;
      if (ctrl_reg[spp_pkg::NVM_START_BIT]) begin
        // Running cycle: only a clear is honoured, op code frozen
        if (!i_wdata[spp_pkg::NVM_START_BIT]) begin
          ctrl_next[spp_pkg::NVM_START_BIT] = 1'b0;
          stop_next = 1'b1;
        end
      end else begin
        ctrl_next[spp_pkg::NVM_START_BIT-1:0] = i_wdata[spp_pkg::NVM_START_BIT-1:0];
        if (want_set && unlock_reg && spp_pkg::op_kind(i_wdata) != spp_pkg::NVM_NONE) begin
          ctrl_next[spp_pkg::NVM_START_BIT] = 1'b1;
          start_next = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl_reg <= spp_pkg::DATA_ZERO;
      key1_reg <= 1'b0;
      unlock_reg <= 1'b0;
      start_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      key1_reg <= key1_next;
      unlock_reg <= unlock_next;
      start_reg <= start_next;
      stop_reg <= stop_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_ctrl = ctrl_reg;
  assign o_unlocked = unlock_reg;
  assign o_start = start_reg;
  assign o_stop = stop_reg;
  assign o_cmd.active = ctrl_reg[spp_pkg::NVM_START_BIT];
  assign o_cmd.kind = spp_pkg::op_kind(ctrl_reg);
  assign o_cmd.op = ctrl_reg[spp_pkg::DATA_W-2:0];

endmodule

// *** rtl/serial_program_port.sv ***
/*
  Serial programming port: control codes, instruction shift-in, result
  readout on the data pin, and the memory control register block.
  Assumes the serial clock and data pins are asynchronous and slow
  (serial period several system clocks); the CPU sits on the o_cpu_* side
  and reaches the registers through the plain register port.
*/
// Function
// - Decode 4-bit code: execute, readout, reserved
// - Execute code: hold CPU, shift 24 bits
// - Execute over next four clocks, shift next code
// - First code after entry forced, nine clocks
// - Readout: eight idle processing clocks first
// - Then shift result register out, 16 clocks
// - Pin input for codes, output for readout
// - Keep driving until next rising serial edge
// - Load op code, unlock, set bit 15
// - Erase codes for memory, rows, words, executive
// - Segment erase codes with protection words
// - Segment data erase codes
// - Write codes for config, data, program rows
// - Start ignored unless key 0x55 then 0xAA
// - Start bit starts cycle, clear terminates it
// - Change on rising, sample falling, LSB first
// - Timing from serial clock, no internal fetch
`timescale 1ns/10ps
module serial_program_port (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_prog_mode,
  input wire logic i_prog_clock_pin,
  input wire logic i_prog_data_pin,
  output logic o_prog_data_pin,
  output logic o_prog_data_oe,
  output spp_pkg::cpu_instr_t o_cpu_instr,
  output logic o_cpu_hold,
  output logic o_cpu_exec_window,
  output logic o_fetch_inhibit,
  input wire logic [spp_pkg::ADDR_W-1:0] i_addr,
  input wire logic [spp_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [spp_pkg::DATA_W-1:0] o_rdata,
  output spp_pkg::nvm_cmd_t o_nvm_cmd,
  output logic o_nvm_start,
  output logic o_nvm_stop
);

  // ----------------------------------------------------------------
  // Pin synchronisation and edge finding
  // ----------------------------------------------------------------
  logic [1:0] pins_sync;
  logic pclk_s;
  logic pdat_s;
  logic pclk_d_reg;
  logic pclk_d_next;
  logic rise;
  logic fall;

  pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_async({i_prog_clock_pin, i_prog_data_pin}),
    .o_sync(pins_sync)
  );

  assign pclk_s = pins_sync[1];
  assign pdat_s = pins_sync[0];

  always_comb begin
    pclk_d_next = pclk_s;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pclk_d_reg <= 1'b0;
    end else begin
      pclk_d_reg <= pclk_d_next;
    end
  end

  // All port timing is taken from serial clock edges
  assign rise = pclk_s & ~pclk_d_reg;
  assign fall = ~pclk_s & pclk_d_reg;

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  logic ctrl_wr;
  logic key_wr;
  logic vis_wr;
  logic [spp_pkg::DATA_W-1:0] nvm_ctrl;
  logic nvm_unlocked;

  assign ctrl_wr = i_wr & (i_addr == spp_pkg::REG_NVM_CTRL);
  assign key_wr = i_wr & (i_addr == spp_pkg::REG_NVM_KEY);
  assign vis_wr = i_wr & (i_addr == spp_pkg::REG_VIS);

  nvm_control u_nvm_control (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ctrl_wr(ctrl_wr),
    .i_key_wr(key_wr),
    .i_wdata(i_wdata),
    .o_ctrl(nvm_ctrl),
    .o_unlocked(nvm_unlocked),
    .o_start(o_nvm_start),
    .o_stop(o_nvm_stop),
    .o_cmd(o_nvm_cmd)
  );

  // ----------------------------------------------------------------
  // Port state machine
  // ----------------------------------------------------------------
  spp_pkg::port_state_t state_reg;
  spp_pkg::port_state_t state_next;
  logic [spp_pkg::CNT_W-1:0] cnt_reg;
  logic [spp_pkg::CNT_W-1:0] cnt_next;
  logic [spp_pkg::CODE_W-1:0] code_reg;
  logic [spp_pkg::CODE_W-1:0] code_next;
  logic [spp_pkg::CODE_W-1:0] code_in;
  logic [spp_pkg::INSTR_W-1:0] ishift_reg;
  logic [spp_pkg::INSTR_W-1:0] ishift_next;
  logic [spp_pkg::INSTR_W-1:0] ishift_in;
  logic [spp_pkg::VIS_W-1:0] vis_reg;
  logic [spp_pkg::VIS_W-1:0] vis_next;
  logic [spp_pkg::VIS_W-1:0] oshift_reg;
  logic [spp_pkg::VIS_W-1:0] oshift_next;
  logic dout_reg;
  logic dout_next;
  logic oe_reg;
  logic oe_next;
  logic win_reg;
  logic win_next;
  spp_pkg::cpu_instr_t instr_reg;
  spp_pkg::cpu_instr_t instr_next;

  // LSB arrives first, so new bits enter at the top and walk down
  assign code_in = {pdat_s, code_reg[spp_pkg::CODE_W-1:1]};
  assign ishift_in = {pdat_s, ishift_reg[spp_pkg::INSTR_W-1:1]};

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    code_next = code_reg;
    ishift_next = ishift_reg;
    oshift_next = oshift_reg;
    dout_next = dout_reg;
    oe_next = oe_reg;
    win_next = win_reg;
    instr_next = instr_reg;
    instr_next.exec = 1'b0;
    vis_next = vis_wr ? i_wdata : vis_reg;
    if (!i_prog_mode) begin
      state_next = spp_pkg::ST_OFF;
      cnt_next = spp_pkg::CNT_ZERO;
      oe_next = 1'b0;
      win_next = 1'b0;
    end else begin
      case (state_reg)
        spp_pkg::ST_OFF: begin
          state_next = spp_pkg::ST_FORCED;
          cnt_next = spp_pkg::CNT_ZERO;
        end
        spp_pkg::ST_FORCED: begin
          // Forced first command: nine clocks, content ignored
          if (fall) begin
            cnt_next = cnt_reg + spp_pkg::CNT_ONE;
            if (cnt_reg == spp_pkg::FORCED_LAST) begin
              instr_next.exec = 1'b1;
              instr_next.word = spp_pkg::NOP_INSTR;
              state_next = spp_pkg::ST_INSTR;
              cnt_next = spp_pkg::CNT_ZERO;
            end
          end
        end
        spp_pkg::ST_INSTR: begin
          if (fall) begin
            ishift_next = ishift_in;
            cnt_next = cnt_reg + spp_pkg::CNT_ONE;
            if (cnt_reg == spp_pkg::INSTR_LAST) begin
              instr_next.exec = 1'b1;
              instr_next.word = ishift_in;
              win_next = 1'b1;
              state_next = spp_pkg::ST_CODE;
              cnt_next = spp_pkg::CNT_ZERO;
            end
          end
        end
        spp_pkg::ST_CODE: begin
          // Pin released only at the first rising edge of the next code
          if (rise && oe_reg) begin
            oe_next = 1'b0;
          end
          if (fall) begin
            code_next = code_in;
            cnt_next = cnt_reg + spp_pkg::CNT_ONE;
            if (cnt_reg == spp_pkg::CODE_LAST) begin
              win_next = 1'b0;
              cnt_next = spp_pkg::CNT_ZERO;
              if (code_in == spp_pkg::CODE_EXEC) begin
                state_next = spp_pkg::ST_INSTR;
              end else if (code_in == spp_pkg::CODE_READOUT) begin
                state_next = spp_pkg::ST_RO_PROC;
              end else begin
                state_next = spp_pkg::ST_CODE;
              end
            end
          end
        end
        spp_pkg::ST_RO_PROC: begin
          if (fall) begin
            cnt_next = cnt_reg + spp_pkg::CNT_ONE;
            if (cnt_reg == spp_pkg::RO_PROC_LAST) begin
              oshift_next = vis_reg;
              state_next = spp_pkg::ST_RO_OUT;
              cnt_next = spp_pkg::CNT_ZERO;
            end
          end
        end
        spp_pkg::ST_RO_OUT: begin
          if (rise) begin
            dout_next = oshift_reg[0];
            oshift_next = {1'b0, oshift_reg[spp_pkg::VIS_W-1:1]};
            oe_next = 1'b1;
          end
          if (fall) begin
            cnt_next = cnt_reg + spp_pkg::CNT_ONE;
            if (cnt_reg == spp_pkg::RO_OUT_LAST) begin
              state_next = spp_pkg::ST_CODE;
              cnt_next = spp_pkg::CNT_ZERO;
            end
          end
        end
        default: begin
          state_next = spp_pkg::ST_OFF;
          cnt_next = spp_pkg::CNT_ZERO;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= spp_pkg::ST_OFF;
      cnt_reg <= spp_pkg::CNT_ZERO;
      code_reg <= '0;
      ishift_reg <= spp_pkg::NOP_INSTR;
      oshift_reg <= spp_pkg::DATA_ZERO;
      vis_reg <= spp_pkg::DATA_ZERO;
      dout_reg <= 1'b0;
      oe_reg <= 1'b0;
      win_reg <= 1'b0;
      instr_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      code_reg <= code_next;
      ishift_reg <= ishift_next;
      oshift_reg <= oshift_next;
      vis_reg <= vis_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      win_reg <= win_next;
      instr_reg <= instr_next;
    end
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  logic [spp_pkg::DATA_W-1:0] rdata_reg;
  logic [spp_pkg::DATA_W-1:0] rdata_next;
  logic [spp_pkg::DATA_W-1:0] status_word;

  assign status_word = {7'h00, nvm_unlocked, o_nvm_cmd.kind, win_reg, oe_reg,
                        i_prog_mode, state_reg};

  always_comb begin
    rdata_next = spp_pkg::DATA_ZERO;
    if (i_rd) begin
      case (i_addr)
        spp_pkg::REG_NVM_CTRL: rdata_next = nvm_ctrl;
        spp_pkg::REG_VIS: rdata_next = vis_reg;
        spp_pkg::REG_STATUS: rdata_next = status_word;
        // Key reads back zero so the key cannot be snooped
        default: rdata_next = spp_pkg::DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_reg <= spp_pkg::DATA_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rdata = rdata_reg;
  assign o_prog_data_pin = dout_reg;
  assign o_prog_data_oe = oe_reg;
  assign o_cpu_instr = instr_reg;
  assign o_cpu_exec_window = win_reg;
  // CPU idle whenever in the mode and not inside an execute window
  assign o_cpu_hold = i_prog_mode & ~win_reg;
  assign o_fetch_inhibit = i_prog_mode;

endmodule

// *** sim/spp_checker.sv ***
/*
  Port assertions for the serial program port.
  Assumes one domain on i_clk with synchronous reset i_srst.
*/
`timescale 1ns/10ps
module spp_checker (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_prog_mode,
  input wire logic o_prog_data_oe,
  input wire spp_pkg::cpu_instr_t o_cpu_instr,
  input wire logic o_cpu_hold,
  input wire logic o_cpu_exec_window,
  input wire logic o_fetch_inhibit,
  input wire logic [spp_pkg::ADDR_W-1:0] i_addr,
  input wire logic [spp_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [spp_pkg::DATA_W-1:0] o_rdata,
  input wire spp_pkg::nvm_cmd_t o_nvm_cmd,
  input wire logic o_nvm_start,
  input wire logic o_nvm_stop
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  // ----------------------------------------------------------------
  // High-time counters
  // ----------------------------------------------------------------
  logic [7:0] win_cnt_reg, win_cnt_next, oe_cnt_reg, oe_cnt_next;
  always_comb begin
    win_cnt_next = o_cpu_exec_window ? win_cnt_reg + 8'h01 : 8'h00;
    oe_cnt_next = o_prog_data_oe ? oe_cnt_reg + 8'h01 : 8'h00;
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      win_cnt_reg <= 8'h00;
      oe_cnt_reg <= 8'h00;
    end else begin
      win_cnt_reg <= win_cnt_next;
      oe_cnt_reg <= oe_cnt_next;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  fetch_gate_a: assert property (o_fetch_inhibit == i_prog_mode)
    else $error("fetch inhibit differs from mode");
  cpu_hold_a: assert property (o_cpu_hold == (i_prog_mode && !o_cpu_exec_window))
    else $error("cpu hold wrong");
  exec_pulse_a: assert property (o_cpu_instr.exec |=> !o_cpu_instr.exec)
    else $error("exec longer than one cycle");
  window_follow_a: assert property (o_cpu_instr.exec && o_cpu_instr.word != spp_pkg::NOP_INSTR
    |-> ##[0:6] o_cpu_exec_window)
    else $error("no exec window after instruction");
  window_len_a: assert property ($fell(o_cpu_exec_window) && i_prog_mode
    |-> win_cnt_reg >= 8'h19 && win_cnt_reg <= 8'h24)
    else $error("exec window not four serial clocks");
  readout_len_a: assert property ($fell(o_prog_data_oe) && i_prog_mode
    |-> oe_cnt_reg >= 8'h7C && oe_cnt_reg <= 8'h84)
    else $error("readout drive not sixteen serial clocks");
  drive_max_a: assert property (oe_cnt_reg <= 8'h84)
    else $error("data pin driven too long");
  mode_off_a: assert property (!i_prog_mode && !$past(i_prog_mode) |-> !o_prog_data_oe)
    else $error("data pin driven outside mode");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == spp_pkg::DATA_ZERO)
    else $error("read data outside read cycle");
  start_cause_a: assert property (o_nvm_start |-> $past(i_wr) && $past(i_wdata[15])
    && $past(i_addr) == spp_pkg::REG_NVM_CTRL)
    else $error("start without control write");
  start_cmd_a: assert property (o_nvm_start |-> o_nvm_cmd.active
    && o_nvm_cmd.kind != spp_pkg::NVM_NONE && o_nvm_cmd.op == $past(i_wdata[14:0]))
    else $error("start with bad command");
  stop_cause_a: assert property (o_nvm_stop |-> $past(o_nvm_cmd.active)
    && !o_nvm_cmd.active && $past(i_wr))
    else $error("stop without clearing write");
  op_frozen_a: assert property ($past(o_nvm_cmd.active) && o_nvm_cmd.active
    |-> $stable(o_nvm_cmd.op))
    else $error("op code changed while running");
  start_c: cover property (o_nvm_start);
  stop_c: cover property (o_nvm_stop);
  readout_c: cover property ($rose(o_prog_data_oe));
endmodule

bind serial_program_port spp_checker i_chk (.i_clk(i_clk), .i_srst(i_srst),
  .i_prog_mode(i_prog_mode), .o_prog_data_oe(o_prog_data_oe), .o_cpu_instr(o_cpu_instr),
  .o_cpu_hold(o_cpu_hold), .o_cpu_exec_window(o_cpu_exec_window),
  .o_fetch_inhibit(o_fetch_inhibit), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_nvm_cmd(o_nvm_cmd), .o_nvm_start(o_nvm_start),
  .o_nvm_stop(o_nvm_stop));

// *** sim/prog_model.sv ***
/*
  Programmer model: makes the serial clock and shifts data both ways.
  Assumes i_clk at 100 MHz; one serial period is 8 system clocks.
*/
`timescale 1ns/10ps
module prog_model (
  input wire logic i_clk,
  input wire logic i_pin,
  output logic o_sclk,
  output logic o_sdata,
  output logic o_sdata_oe
);
  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_sdata_oe = 1'b1;
  end
  // ----------------------------------------------------------------
  // Shift n bits; clock stands low between calls
  // ----------------------------------------------------------------
  task automatic shift(input int n, input logic [31:0] v, input logic drv,
      output logic [31:0] q);
    q = 32'h00000000;
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      o_sclk <= 1'b1;
      o_sdata <= v[i];
      o_sdata_oe <= drv;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b0;
      q[i] = i_pin;
      repeat (3) @(posedge i_clk);
    end
  endtask
endmodule

// *** sim/tb_top.sv ***
/*
  Self-checking bench for the serial program port.
  Assumes prog_model on the serial pins and a plain register port master.
*/
`timescale 1ns/10ps
module tb_top;
  logic i_clk, i_srst, i_prog_mode, i_wr, i_rd, sclk, p_d, p_oe, flt, pin;
  logic [3:0] i_addr;
  logic [15:0] i_wdata, rd, o_rdata;
  logic [31:0] q;
  logic o_prog_data_pin, o_prog_data_oe, o_cpu_hold, o_cpu_exec_window, o_fetch_inhibit;
  logic o_nvm_start, o_nvm_stop;
  spp_pkg::cpu_instr_t o_cpu_instr;
  spp_pkg::nvm_cmd_t o_nvm_cmd;
  logic [23:0] exec_w;
  int exec_n = 0, exp_n = 0;
  int fail_count = 0, n_compared = 0, cyc = 0;
  localparam logic [15:0] OPS [15] = '{16'h407F, 16'h4075, 16'h4074, 16'h4072, 16'h4071,
    16'h406E, 16'h405E, 16'h404E, 16'h4066, 16'h4056, 16'h4046,
    16'h4008, 16'h4005, 16'h4004, 16'h4001};
  // Released wire toggles so a stale value never looks valid
  assign pin = o_prog_data_oe ? o_prog_data_pin : (p_oe ? p_d : flt);
  serial_program_port i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_prog_mode(i_prog_mode),
    .i_prog_clock_pin(sclk), .i_prog_data_pin(pin), .o_prog_data_pin(o_prog_data_pin),
    .o_prog_data_oe(o_prog_data_oe), .o_cpu_instr(o_cpu_instr), .o_cpu_hold(o_cpu_hold),
    .o_cpu_exec_window(o_cpu_exec_window), .o_fetch_inhibit(o_fetch_inhibit),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_nvm_cmd(o_nvm_cmd), .o_nvm_start(o_nvm_start), .o_nvm_stop(o_nvm_stop));
  prog_model i_prog (.i_clk(i_clk), .i_pin(pin), .o_sclk(sclk), .o_sdata(p_d),
    .o_sdata_oe(p_oe));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    flt <= ~flt;
    cyc <= cyc + 1;
    if (o_cpu_instr.exec === 1'b1) begin
      exec_n <= exec_n + 1;
      exec_w <= o_cpu_instr.word;
    end
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  // Instruction bits, then count and word of the exec pulse
  task automatic instr_chk(input logic [23:0] w);
    i_prog.shift(24, {8'h00, w}, 1'b1, q);
    repeat (2) @(posedge i_clk);
    exp_n++;
    chk(exec_n, exp_n);
    chk(exec_w, w);
  endtask
  task automatic try_start(input logic [15:0] k1, k2, op, input spp_pkg::nvm_kind_t k);
    reg_wr(spp_pkg::REG_NVM_KEY, k1);
    reg_wr(spp_pkg::REG_NVM_KEY, k2);
    reg_wr(spp_pkg::REG_NVM_CTRL, op);
    chk(o_nvm_start, k != spp_pkg::NVM_NONE);
    if (k != spp_pkg::NVM_NONE) begin
      chk(o_nvm_cmd.kind, k);
      repeat (20) @(posedge i_clk);
      reg_wr(spp_pkg::REG_NVM_CTRL, op & 16'h7FFF);
      chk(o_nvm_stop, 1'b1);
      chk(o_nvm_cmd.active, 1'b0);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    flt = 1'b0;
    i_srst = 1'b1;
    i_prog_mode = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 16'h0000;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    chk(o_nvm_cmd, 18'h00000);
    reg_rd(4'hF, rd);
    chk(rd, 16'h0000);
    reg_rd(spp_pkg::REG_NVM_KEY, rd);
    chk(rd, 16'h0000);
    reg_wr(spp_pkg::REG_VIS, 16'hA5C3);
    reg_rd(spp_pkg::REG_VIS, rd);
    chk(rd, 16'hA5C3);
    i_prog_mode <= 1'b1;
    @(posedge i_clk);
    chk(o_fetch_inhibit, 1'b1);
    chk(o_cpu_hold, 1'b1);
    i_prog.shift(9, 32'h000001FF, 1'b1, q);
    repeat (6) @(posedge i_clk);
    chk(exec_n, 1);
    chk(exec_w, 24'h000000);
    i_prog.shift(16, 32'h00003456, 1'b1, q);
    chk(o_cpu_hold, 1'b1);
    i_prog.shift(8, 32'h00000012, 1'b1, q);
    i_prog.shift(2, 32'h00000000, 1'b1, q);
    chk(o_cpu_exec_window, 1'b1);
    chk(o_cpu_hold, 1'b0);
    exp_n = 2;
    chk(exec_w, 24'h123456);
    i_prog.shift(2, 32'h00000000, 1'b1, q);
    instr_chk(24'hBB1B96);
    i_prog.shift(4, 32'h00000000, 1'b1, q);
    instr_chk(24'h000000);
    i_prog.shift(4, 32'h00000001, 1'b1, q);
    i_prog.shift(8, 32'h00000000, 1'b1, q);
    chk(o_prog_data_oe, 1'b0);
    i_prog.shift(16, 32'h00000000, 1'b0, q);
    chk(q[15:0], 16'hA5C3);
    chk(o_prog_data_oe, 1'b1);
    i_prog.shift(1, 32'h00000000, 1'b1, q);
    chk(o_prog_data_oe, 1'b0);
    i_prog.shift(3, 32'h00000000, 1'b1, q);
    instr_chk(24'h5A0F33);
    for (int c = 2; c < 16; c++) begin
      i_prog.shift(4, c, 1'b1, q);
      i_prog.shift(4, 32'h00000000, 1'b1, q);
      instr_chk(24'h0F0000 | 24'(c));
    end
    for (int i = 0; i < 15; i++) begin
      try_start(16'h0055, 16'h00AA, OPS[i] | 16'h8000,
        (i < 11) ? spp_pkg::NVM_ERASE : spp_pkg::NVM_WRITE);
    end
    reg_wr(spp_pkg::REG_NVM_CTRL, 16'hC07F);
    chk(o_nvm_start, 1'b0);
    try_start(16'h00AA, 16'h0055, 16'hC07F, spp_pkg::NVM_NONE);
    try_start(16'h0055, 16'h0055, 16'hC075, spp_pkg::NVM_NONE);
    try_start(16'h0055, 16'h00AA, 16'hC000, spp_pkg::NVM_NONE);
    i_prog_mode <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk(o_fetch_inhibit, 1'b0);
    chk(o_prog_data_oe, 1'b0);
    close_out();
  end
endmodule
